// ==== inc/core_status_pkg.sv ====
// Constants and carrier types shared by the core status and control register bank.
package core_status_pkg;
    localparam logic [7:0] ALU_FLAG_ADDR   = 8'h04;
    localparam logic [7:0] TIMER_CTRL_ADDR = 8'h05;
    localparam logic [7:0] CPU_STATE_ADDR  = 8'h06;
    localparam int CARRY_BIT       = 0;
    localparam int DIGIT_CARRY_BIT = 1;
    localparam int ZERO_BIT        = 2;
    localparam int OVERFLOW_BIT    = 3;
    localparam int FIRST_MODE_LSB  = 4;
    localparam int SECOND_MODE_LSB = 6;
    localparam int POWER_DOWN_BIT  = 2;
    localparam int TIME_OUT_BIT    = 3;
    localparam int GLOBAL_IRQ_BIT  = 4;
    localparam int STACK_AVAIL_BIT = 5;
    localparam int EXT_EDGE_BIT    = 7;
    localparam int PIN_EDGE_BIT    = 6;
    localparam int CLK_SRC_BIT     = 5;
    localparam int PRESCALE_LSB    = 1;
    localparam logic [7:0] ALU_FLAG_RESET   = 8'h00;
    localparam logic [6:0] TIMER_CTRL_RESET = 7'h00;
    localparam logic       GLOBAL_IRQ_RESET = 1'b0;
    localparam logic [1:0] PTR_DECREMENT    = 2'h0;
    localparam logic [1:0] PTR_INCREMENT    = 2'h1;
    localparam logic [3:0] PRESCALE_MAX_LOG = 4'h8;

    typedef enum logic [4:0]
    {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR, OP_COMP,
        OP_RLC, OP_RRC, OP_RLN, OP_RRN, OP_SWAP, OP_MOVE, OP_CLR,
        OP_INC, OP_DEC, OP_BCLR, OP_BSET
    } alu_op_t;

    typedef struct packed
    {
        logic overflow;
        logic z;
        logic digitCarry;
        logic c;
    } alu_flags_t;

    typedef struct packed
    {
        alu_op_t    op;
        logic [7:0] wOperand;
        logic [7:0] fOperand;
        logic [2:0] bitSel;
        logic       destIsFile;
        logic [7:0] destAddr;
    } exec_req_t;
endpackage

// ==== hdl/alu_flag_unit.sv ====
// Combinational ALU producing the result, the flag values and the flags each operation touches.
`timescale 1ns/1ns
module alu_flag_unit
(
    input  wire core_status_pkg::alu_op_t    op,       // Operation.
    input  wire logic [7:0]                  a,        // Working register operand.
    input  wire logic [7:0]                  b,        // File register or immediate operand.
    input  wire logic [2:0]                  bitSel,   // Bit number for bit operations.
    input  wire logic                        carryIn,  // Current carry flag.
    output logic [7:0]                       result,   // Operation result.
    output core_status_pkg::alu_flags_t      flags,    // Flag values from result logic.
    output logic [3:0]                       affect    // Flags written by this operation.
);
    import core_status_pkg::*;

    // Returns {digit carry, carry, sum}; a subtraction passes the inverted operand.
    function automatic logic [9:0] addFlags(input logic [7:0] x, input logic [7:0] y, input logic cin);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        return {n[4], s};
    endfunction

    logic [9:0] sum;
    logic       cOut;
    logic [7:0] y;

    always_comb
    begin
        y = b;
        cOut = carryIn;
        affect = 4'h0;
        sum = 10'h000;
        case (op)
            OP_ADD:  begin sum = addFlags(a, b, 1'b0);  affect = 4'hf; end
            OP_ADDC: begin sum = addFlags(a, b, carryIn); affect = 4'hf; end
            OP_SUB:  begin sum = addFlags(b, ~a, 1'b1); affect = 4'hf; end
            OP_SUBB: begin sum = addFlags(b, ~a, carryIn); affect = 4'hf; end
            OP_INC:  begin sum = addFlags(b, 8'h01, 1'b0); affect = 4'hf; end
            OP_DEC:  begin sum = addFlags(b, 8'hff, 1'b0); affect = 4'hf; end
            OP_AND:  begin y = a & b; affect = 4'h4; end
            OP_OR:   begin y = a | b; affect = 4'h4; end
            OP_XOR:  begin y = a ^ b; affect = 4'h4; end
            OP_COMP: begin y = ~b; affect = 4'h4; end
            OP_CLR:  begin y = 8'h00; affect = 4'h4; end
            OP_RLC:  begin y = {b[6:0], carryIn}; cOut = b[7]; affect = 4'h1; end
            OP_RRC:  begin y = {carryIn, b[7:1]}; cOut = b[0]; affect = 4'h1; end
            OP_RLN:  y = {b[6:0], b[7]};
            OP_RRN:  y = {b[0], b[7:1]};
            OP_SWAP: y = {b[3:0], b[7:4]};
            OP_MOVE: y = a;
            OP_BCLR: y = b & ~(8'h01 << bitSel);
            OP_BSET: y = b | (8'h01 << bitSel);
            default: y = b;
        endcase
    end

    wire isArith = affect[OVERFLOW_BIT];
    wire [7:0] yArith = (op == OP_SUB || op == OP_SUBB) ? ~a : (op == OP_INC ? 8'h01 : (op == OP_DEC ? 8'hff : a));
    wire [7:0] xArith = (op == OP_ADD || op == OP_ADDC) ? b : b;

    assign result   = isArith ? sum[7:0] : y;
    assign flags.c  = isArith ? sum[8] : cOut;
    assign flags.digitCarry = sum[9];
    assign flags.z  = (result == 8'h00);
    assign flags.overflow = (xArith[7] == yArith[7]) && (sum[7] != xArith[7]);
endmodule

// ==== hdl/pointer_step.sv ====
// Next indirect pointer value after an access, chosen by a two-bit mode.
`timescale 1ns/1ns
module pointer_step
(
    input  wire logic [7:0] ptrIn,   // Pointer before the access.
    input  wire logic [1:0] mode,    // Update mode.
    output logic [7:0]      ptrOut   // Pointer after the access.
);
    import core_status_pkg::*;

    // Wrapping to zero raises no flag; this path never reaches the flag register.
    assign ptrOut = (mode == PTR_DECREMENT) ? ptrIn - 8'h01 :
                    (mode == PTR_INCREMENT) ? ptrIn + 8'h01 : ptrIn;
endmodule

// ==== hdl/core_status_control_registers.sv ====
// ALU flag, timer zero control and CPU state registers with their effects on the core.
`timescale 1ns/1ns
// Behaviour
// - Flag-affecting ops block data write to flags.
// - Clear of flag register gives 0000u1uu.
// - Bit, swap and move ops keep flags.
// - Carry flags act as borrow in subtraction.
// - Overflow set on signed range overflow.
// - ALU takes one or two operands.
// - Pointer mode: 00 down, 01 up, 1x hold.
// - Rotate through carry loads shifted-out bit.
// - Global enable gates every interrupt source.
// - Time-out, power-down, stack bits ignore writes.
// - Bit 7 picks external interrupt edge.
// - Bit 5 picks timer clock source.
// - Bits 4:1 set prescale, 1xxx gives 1:256.
// - Bit 0 reads zero; register resets zero.
// - Upper mode second pointer, lower first.
// - Pointer steps never change ALU flags.
module core_status_control_registers
#(
    parameter int IRQ_SOURCES = 8
)
(
    input  wire logic                         core_clk,            // Core clock.
    input  wire logic                         reset,               // Asynchronous reset.
    input  wire logic                         execValid,           // Instruction executes now.
    input  wire core_status_pkg::exec_req_t   execReq,             // Instruction operands.
    input  wire logic                         rdEn,                // Register read request.
    input  wire logic [7:0]                   rdAddr,              // Register read address.
    output logic [7:0]                        rdData,              // Read data.
    output logic [7:0]                        resultData,          // ALU result.
    output logic                              resultValid,         // Result strobe.
    output core_status_pkg::alu_flags_t       flagsOut,            // Current ALU flags.
    input  wire logic                         hwTimeOut,           // Time-out level.
    input  wire logic                         hwPowerDown,         // Power-down level.
    input  wire logic                         hwStackAvailable,    // Stack available level.
    input  wire logic [IRQ_SOURCES-1:0]       irqSourcePending,    // Enabled pending sources.
    output logic                              irqRequest,          // Gated interrupt request.
    output logic                              globalIrqEnable,     // Global enable bit.
    input  wire logic                         extIrqPin,           // External interrupt pin.
    output logic                              extIrqEvent,         // Selected edge seen.
    input  wire logic                         timerPin,            // External timer clock pin.
    output logic                              timerPinTick,        // Timer count pulse.
    output logic                              timerClockInternal,  // Instruction clock chosen.
    output logic [3:0]                        prescaleLog,         // Log2 of division ratio.
    input  wire logic [7:0]                   firstPointerIn,      // First pointer value.
    input  wire logic                         firstPointerAccess,  // First pointer used.
    output logic [7:0]                        firstPointerOut,     // Updated first pointer.
    output logic                              firstPointerUpdated, // First update strobe.
    input  wire logic [7:0]                   secondPointerIn,     // Second pointer value.
    input  wire logic                         secondPointerAccess, // Second pointer used.
    output logic [7:0]                        secondPointerOut,    // Updated second pointer.
    output logic                              secondPointerUpdated // Second update strobe.
);
    import core_status_pkg::*;

    // Division ratio as a power of two; any code with the top bit set saturates.
    function automatic logic [3:0] prescaleDecode(input logic [3:0] code);
        return code[3] ? PRESCALE_MAX_LOG : {1'b0, code[2:0]};
    endfunction

    logic [7:0] aluFlag_reg;
    logic [7:0] aluFlag_next;
    logic [6:0] timerCtrl_reg;
    logic [6:0] timerCtrl_next;
    logic       globalIrq_reg;
    logic       globalIrq_next;
    logic [2:0] hwState_reg;
    logic [7:0] rdData_reg;
    logic [7:0] result_reg;
    logic       resultValid_reg;
    logic       irqRequest_reg;
    logic       extPinPrev_reg;
    logic       timerPinPrev_reg;
    logic       extIrqEvent_reg;
    logic       timerPinTick_reg;
    logic [7:0] firstPtr_reg;
    logic       firstUpd_reg;
    logic [7:0] secondPtr_reg;
    logic       secondUpd_reg;

    logic [7:0] aluResult;
    alu_flags_t aluFlags;
    logic [3:0] aluAffect;
    logic [7:0] firstPtrNext;
    logic [7:0] secondPtrNext;

    alu_flag_unit aluUnit
    (
        .op      (execReq.op),
        .a       (execReq.wOperand),
        .b       (execReq.fOperand),
        .bitSel  (execReq.bitSel),
        .carryIn (aluFlag_reg[CARRY_BIT]),
        .result  (aluResult),
        .flags   (aluFlags),
        .affect  (aluAffect)
    );

    pointer_step firstStep
    (
        .ptrIn  (firstPointerIn),
        .mode   (aluFlag_reg[FIRST_MODE_LSB +: 2]),
        .ptrOut (firstPtrNext)
    );

    pointer_step secondStep
    (
        .ptrIn  (secondPointerIn),
        .mode   (aluFlag_reg[SECOND_MODE_LSB +: 2]),
        .ptrOut (secondPtrNext)
    );

    wire       fileWrite = execValid & execReq.destIsFile;
    wire       aluDest   = fileWrite && (execReq.destAddr == ALU_FLAG_ADDR);
    wire       timerDest = fileWrite && (execReq.destAddr == TIMER_CTRL_ADDR);
    wire       cpuDest   = fileWrite && (execReq.destAddr == CPU_STATE_ADDR);
    wire [3:0] affectNow = execValid ? aluAffect : 4'h0;
    wire       anyFlag   = |affectNow;
    wire [3:0] logicBits = {aluFlags.overflow, aluFlags.z, aluFlags.digitCarry, aluFlags.c};

    // A flag-touching op into this register keeps the data off all four low bits.
    wire [3:0] keptLow   = (aluDest && !anyFlag) ? aluResult[3:0] : aluFlag_reg[3:0];
    wire [3:0] lowNext   = (affectNow & logicBits) | (~affectNow & keptLow);

    assign aluFlag_next   = {aluDest ? aluResult[7:4] : aluFlag_reg[7:4], lowNext};
    assign timerCtrl_next = timerDest ? aluResult[7:1] : timerCtrl_reg;
    assign globalIrq_next = cpuDest ? aluResult[GLOBAL_IRQ_BIT] : globalIrq_reg;

    wire [7:0] timerRead = {timerCtrl_reg, 1'b0};
    wire [7:0] cpuRead   = {2'h0, hwState_reg[2], globalIrq_reg, hwState_reg[1], hwState_reg[0], 2'h0};
    wire [7:0] readMux   = (rdAddr == ALU_FLAG_ADDR)   ? aluFlag_reg :
                           (rdAddr == TIMER_CTRL_ADDR) ? timerRead :
                           (rdAddr == CPU_STATE_ADDR)  ? cpuRead : 8'h00;

    wire extRising  = timerCtrl_reg[EXT_EDGE_BIT - 1];
    wire pinRising  = timerCtrl_reg[PIN_EDGE_BIT - 1];
    wire useInstClk = timerCtrl_reg[CLK_SRC_BIT - 1];
    wire extEdge    = extRising ? (extIrqPin & ~extPinPrev_reg) : (~extIrqPin & extPinPrev_reg);
    wire pinEdge    = pinRising ? (timerPin & ~timerPinPrev_reg) : (~timerPin & timerPinPrev_reg);

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            aluFlag_reg   <= ALU_FLAG_RESET;
            timerCtrl_reg <= TIMER_CTRL_RESET;
            globalIrq_reg <= GLOBAL_IRQ_RESET;
        end
        else
        begin
            aluFlag_reg   <= aluFlag_next;
            timerCtrl_reg <= timerCtrl_next;
            globalIrq_reg <= globalIrq_next;
        end
    end

    // Hardware-owned state bits follow their sources and never take a write.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            hwState_reg <= 3'h0;
        end
        else
        begin
            hwState_reg <= {hwStackAvailable, hwTimeOut, hwPowerDown};
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdData_reg      <= 8'h00;
            result_reg      <= 8'h00;
            resultValid_reg <= 1'b0;
        end
        else
        begin
            rdData_reg      <= rdEn ? readMux : rdData_reg;
            result_reg      <= execValid ? aluResult : result_reg;
            resultValid_reg <= execValid;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            irqRequest_reg   <= 1'b0;
            extPinPrev_reg   <= 1'b0;
            timerPinPrev_reg <= 1'b0;
            extIrqEvent_reg  <= 1'b0;
            timerPinTick_reg <= 1'b0;
        end
        else
        begin
            irqRequest_reg   <= globalIrq_reg & (|irqSourcePending);
            extPinPrev_reg   <= extIrqPin;
            timerPinPrev_reg <= timerPin;
            extIrqEvent_reg  <= extEdge;
            timerPinTick_reg <= pinEdge & ~useInstClk;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            firstPtr_reg  <= 8'h00;
            firstUpd_reg  <= 1'b0;
            secondPtr_reg <= 8'h00;
            secondUpd_reg <= 1'b0;
        end
        else
        begin
            firstPtr_reg  <= firstPointerAccess ? firstPtrNext : firstPtr_reg;
            firstUpd_reg  <= firstPointerAccess;
            secondPtr_reg <= secondPointerAccess ? secondPtrNext : secondPtr_reg;
            secondUpd_reg <= secondPointerAccess;
        end
    end

    logic [3:0] prescale_reg;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            prescale_reg <= 4'h0;
        end
        else
        begin
            prescale_reg <= prescaleDecode(timerCtrl_next[PRESCALE_LSB - 1 +: 4]);
        end
    end

    assign rdData               = rdData_reg;
    assign resultData           = result_reg;
    assign resultValid          = resultValid_reg;
    assign flagsOut             = aluFlag_reg[3:0];
    assign irqRequest           = irqRequest_reg;
    assign globalIrqEnable      = globalIrq_reg;
    assign extIrqEvent          = extIrqEvent_reg;
    assign timerPinTick         = timerPinTick_reg;
    assign timerClockInternal   = useInstClk;
    assign prescaleLog          = prescale_reg;
    assign firstPointerOut      = firstPtr_reg;
    assign firstPointerUpdated  = firstUpd_reg;
    assign secondPointerOut     = secondPtr_reg;
    assign secondPointerUpdated = secondUpd_reg;
endmodule

// ==== verification/core_status_control_registers_sva.sv ====
// Port-level assertions and covers for the core status and control register bank.
`timescale 1ns/1ns
module core_status_control_registers_sva
#(
    parameter int IRQ_SOURCES = 8
)
(
    input wire logic                        core_clk,            // Core clock.
    input wire logic                        reset,               // Asynchronous reset.
    input wire logic                        execValid,           // Execute strobe.
    input wire core_status_pkg::exec_req_t  execReq,             // Instruction fields.
    input wire logic                        rdEn,                // Read strobe.
    input wire logic [7:0]                  rdAddr,              // Read address.
    input wire logic [7:0]                  rdData,              // Read data.
    input wire logic                        resultValid,         // Result strobe.
    input wire core_status_pkg::alu_flags_t flagsOut,            // Current flags.
    input wire logic [IRQ_SOURCES-1:0]      irqSourcePending,    // Pending sources.
    input wire logic                        irqRequest,          // Gated request.
    input wire logic                        globalIrqEnable,     // Global enable.
    input wire logic                        timerPinTick,        // Pin count pulse.
    input wire logic                        timerClockInternal,  // Internal source.
    input wire logic [3:0]                  prescaleLog,         // Division ratio log.
    input wire logic                        firstPointerAccess,  // First pointer used.
    input wire logic                        firstPointerUpdated, // First update strobe.
    input wire logic                        secondPointerUpdated // Second update strobe.
);
    import core_status_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire toFile  = execValid && execReq.destIsFile;
    wire toFlags = toFile && execReq.destAddr == ALU_FLAG_ADDR;
    wire toTimer = toFile && execReq.destAddr == TIMER_CTRL_ADDR && execReq.op == OP_MOVE;
    wire keepOp  = execReq.op inside {OP_BCLR, OP_BSET, OP_SWAP, OP_MOVE};

    a_result_strobe: assert property (execValid |=> resultValid) else $error("result strobe missing");
    a_clear_flags: assert property (toFlags && execReq.op == OP_CLR |=> flagsOut ==
        {$past(flagsOut.overflow), 1'b1, $past(flagsOut.digitCarry), $past(flagsOut.c)})
        else $error("clear changed flags");
    a_keep_flags: assert property (execValid && keepOp && !toFlags |=> $stable(flagsOut))
        else $error("flags moved on keep op");
    a_prescale_map: assert property (toTimer |=> prescaleLog ==
        ($past(execReq.wOperand[4]) ? 4'h8 : {1'b0, $past(execReq.wOperand[3:1])})) else $error("prescale wrong");
    a_clock_source: assert property (toTimer |=> timerClockInternal == $past(execReq.wOperand[5]))
        else $error("clock source wrong");
    a_pin_gated: assert property (timerClockInternal && $past(timerClockInternal) |-> !timerPinTick)
        else $error("pin tick with internal clock");
    a_timer_bit0: assert property (rdEn && rdAddr == TIMER_CTRL_ADDR |=> rdData[0] == 1'b0)
        else $error("timer bit 0 set");
    a_irq_masked: assert property (!globalIrqEnable |=> !irqRequest) else $error("request while disabled");
    a_irq_raise: assert property (globalIrqEnable && |irqSourcePending |=> irqRequest)
        else $error("request missing");
    a_pointer_quiet: assert property (firstPointerAccess && !execValid |=> firstPointerUpdated ##0
        $stable(flagsOut)) else $error("pointer step disturbed flags");

    c_clear: cover property (toFlags && execReq.op == OP_CLR);
    c_irq: cover property (irqRequest);
    c_ptrs: cover property (firstPointerUpdated && secondPointerUpdated);
endmodule
bind core_status_control_registers core_status_control_registers_sva #(.IRQ_SOURCES(IRQ_SOURCES)) sva_u
(
    .core_clk(core_clk), .reset(reset), .execValid(execValid), .execReq(execReq), .rdEn(rdEn),
    .rdAddr(rdAddr), .rdData(rdData), .resultValid(resultValid), .flagsOut(flagsOut),
    .irqSourcePending(irqSourcePending), .irqRequest(irqRequest), .globalIrqEnable(globalIrqEnable),
    .timerPinTick(timerPinTick), .timerClockInternal(timerClockInternal), .prescaleLog(prescaleLog),
    .firstPointerAccess(firstPointerAccess), .firstPointerUpdated(firstPointerUpdated),
    .secondPointerUpdated(secondPointerUpdated)
);

// ==== verification/core_datapath_model.sv ====
// Instruction datapath stand-in that issues executions and register reads.
`timescale 1ns/1ns
module core_datapath_model
(
    input  wire logic                  core_clk,  // Core clock.
    output logic                       execValid, // Execute strobe.
    output core_status_pkg::exec_req_t execReq,   // Instruction fields.
    output logic                       rdEn,      // Read strobe.
    output logic [7:0]                 rdAddr,    // Read address.
    input  wire logic [7:0]            rdData     // Read data.
);
    import core_status_pkg::*;
    initial
    begin
        execValid = 1'b0;
        execReq = '0;
        rdEn = 1'b0;
        rdAddr = 8'h00;
    end
    // Released fields are inverted so that no stale value can pass for a live one.
    task automatic issue(input alu_op_t op, input logic [7:0] w, input logic [7:0] f, input logic [7:0] da);
        @(posedge core_clk);
        execValid <= 1'b1;
        execReq <= '{op: op, wOperand: w, fOperand: f, bitSel: 3'h0, destIsFile: 1'b1, destAddr: da};
        @(posedge core_clk);
        execValid <= 1'b0;
        execReq <= exec_req_t'(~execReq);
        #1;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        @(posedge core_clk);
        rdEn <= 1'b0;
        rdAddr <= ~a;
        #1 d = rdData;
    endtask
endmodule

// ==== verification/core_status_control_registers_test.sv ====
// Self-checking bench for the core status and control register bank.
`timescale 1ns/1ns
module core_status_control_registers_test;
    import core_status_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, execValid, rdEn, resultValid, irqRequest, globalIrqEnable;
    logic hwTimeOut = 1'b0, hwPowerDown = 1'b0, hwStackAvailable = 1'b0, extIrqPin = 1'b0, timerPin = 1'b0;
    logic extIrqEvent, timerPinTick, timerClockInternal, firstPointerAccess = 1'b0, secondPointerAccess = 1'b0;
    logic firstPointerUpdated, secondPointerUpdated;
    logic [7:0] rdAddr, rdData, resultData, firstPointerOut, secondPointerOut, v, w, f;
    logic [7:0] firstPointerIn = 8'h00, secondPointerIn = 8'h00, irqSourcePending = 8'h00;
    logic [3:0] prescaleLog, expFl;
    logic [11:0] e;
    exec_req_t execReq;
    alu_flags_t flagsOut;
    alu_op_t op;
    alu_op_t opTab[12] = '{OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR,
        OP_RLC, OP_RRC, OP_SWAP, OP_MOVE, OP_BSET};
    int n_fail = 0, checks_done = 0;

    always #20 core_clk = ~core_clk;
    core_datapath_model dp (.core_clk(core_clk), .execValid(execValid), .execReq(execReq), .rdEn(rdEn),
        .rdAddr(rdAddr), .rdData(rdData));
    core_status_control_registers dut_u (.*);

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic readChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        dp.read(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask
    task automatic conclude;
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [11:0] aluExp(input alu_op_t o, input logic [7:0] a, input logic [7:0] b0,
        input logic [3:0] fl);
        logic [7:0] b;
        logic       cin;
        logic [8:0] s;
        logic [4:0] h;
        b = (o == OP_SUB || o == OP_SUBB) ? ~a : a;
        cin = (o == OP_ADD) ? 1'b0 : (o == OP_SUB) ? 1'b1 : fl[0];
        s = {1'b0, b0} + {1'b0, b} + 9'(cin);
        h = {1'b0, b0[3:0]} + {1'b0, b[3:0]} + 5'(cin);
        case (o)
            OP_AND: return {a & b0, fl[3], (a & b0) == 8'h00, fl[1:0]};
            OP_OR: return {a | b0, fl[3], (a | b0) == 8'h00, fl[1:0]};
            OP_XOR: return {a ^ b0, fl[3], (a ^ b0) == 8'h00, fl[1:0]};
            OP_RLC: return {b0[6:0], fl[0], fl[3:1], b0[7]};
            OP_RRC: return {fl[0], b0[7:1], fl[3:1], b0[0]};
            OP_SWAP: return {b0[3:0], b0[7:4], fl};
            OP_MOVE: return {a, fl};
            OP_BSET: return {b0 | 8'h01, fl};
            default: return {s[7:0], (b0[7] == b[7]) && (s[7] != b0[7]), s[7:0] == 8'h00, h[4], s[8]};
        endcase
    endfunction
    function automatic logic [7:0] ptrExp(input logic [7:0] p, input logic [1:0] m);
        return m[1] ? p : m[0] ? p + 8'h01 : p - 8'h01;
    endfunction
    task automatic edgeCase(input logic s);
        logic gotE = 1'b0, gotT = 1'b0;
        dp.issue(OP_MOVE, {s, s, 6'h00}, 8'h00, TIMER_CTRL_ADDR);
        @(posedge core_clk);
        extIrqPin <= !s;
        timerPin <= !s;
        repeat (3) @(posedge core_clk);
        extIrqPin <= s;
        timerPin <= s;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            #1 gotE |= extIrqEvent;
            gotT |= timerPinTick;
        end
        chk("extIrqEvent", 8'h01, {7'h0, gotE});
        chk("timerPinTick", 8'h01, {7'h0, gotT});
        if (gotE !== 1'b1 || gotT !== 1'b1)
            conclude();
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'hfa9040cf));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        readChk(TIMER_CTRL_ADDR, 8'h00);
        readChk(CPU_STATE_ADDR, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            dp.issue(OP_MOVE, {2'(m), 2'(m) ^ 2'h1, 4'h0}, 8'h00, ALU_FLAG_ADDR);
            @(posedge core_clk);
            firstPointerIn <= 8'h00;
            secondPointerIn <= 8'hff;
            firstPointerAccess <= 1'b1;
            secondPointerAccess <= 1'b1;
            @(posedge core_clk);
            firstPointerAccess <= 1'b0;
            secondPointerAccess <= 1'b0;
            @(posedge core_clk);
            #1 chk("firstPointerOut", ptrExp(8'h00, 2'(m) ^ 2'h1), firstPointerOut);
            chk("secondPointerOut", ptrExp(8'hff, 2'(m)), secondPointerOut);
            chk("flagsOut", 8'h00, {4'h0, flagsOut});
        end
        dp.issue(OP_MOVE, 8'hff, 8'h00, ALU_FLAG_ADDR);
        chk("flagsOut", 8'h0f, {4'h0, flagsOut});
        dp.issue(OP_CLR, 8'h00, 8'h55, ALU_FLAG_ADDR);
        readChk(ALU_FLAG_ADDR, 8'h0f);
        dp.issue(OP_ADD, 8'h78, 8'h78, ALU_FLAG_ADDR);
        readChk(ALU_FLAG_ADDR, 8'hfa);
        expFl = 4'ha;
        for (int i = 0; i < 48; i++)
        begin
            op = opTab[$urandom_range(11)];
            w = 8'($urandom);
            f = (i < 4) ? w : 8'($urandom);
            e = aluExp(op, w, f, expFl);
            dp.issue(op, w, f, 8'h20);
            chk("resultData", e[11:4], resultData);
            chk("flagsOut", {4'h0, e[3:0]}, {4'h0, flagsOut});
            expFl = e[3:0];
        end
        for (int c = 0; c < 16; c++)
        begin
            dp.issue(OP_MOVE, {3'h1, 4'(c), 1'b1}, 8'h00, TIMER_CTRL_ADDR);
            chk("prescaleLog", c[3] ? 8'h08 : 8'(c[2:0]), {4'h0, prescaleLog});
            chk("timerClockInternal", 8'h01, {7'h0, timerClockInternal});
            readChk(TIMER_CTRL_ADDR, {3'h1, 4'(c), 1'b0});
        end
        edgeCase(1'b1);
        edgeCase(1'b0);
        @(posedge core_clk);
        v = 8'($urandom);
        {hwStackAvailable, hwTimeOut, hwPowerDown} <= v[2:0];
        irqSourcePending <= 8'h10;
        repeat (2) @(posedge core_clk);
        #1 chk("irqRequest", 8'h00, {7'h0, irqRequest});
        for (int g = 1; g >= 0; g--)
        begin
            dp.issue(OP_MOVE, g ? 8'hff : 8'h00, 8'h00, CPU_STATE_ADDR);
            repeat (2) @(posedge core_clk);
            #1 chk("irqRequest", 8'(g), {7'h0, irqRequest});
            chk("globalIrqEnable", 8'(g), {7'h0, globalIrqEnable});
            readChk(CPU_STATE_ADDR, {2'h0, v[2], 1'(g), v[1:0], 2'h0});
        end
        conclude();
    end
endmodule
